// ===== rtl/trig_out_pkg.sv
`default_nettype none
package trig_out_pkg;
    // ----------------------------------------
    // line layout and timing
    // ----------------------------------------
    localparam int STATIC_COUNT  = 8;
    localparam int EVENT_COUNT   = 5;
    localparam int LINE_COUNT    = 16;
    localparam int PIPE_DEPTH    = 8;
    localparam int SEL_WIDTH     = 4;
    localparam int SRC_WIDTH     = 16;
    // bit positions within trigLines (line 16 is bit 0)
    localparam int POS_EVENT_LO  = 0;
    localparam int POS_EXTRACT   = 5;
    localparam int POS_TRACEPT   = 6;
    localparam int POS_BREAK     = 7;
    localparam int POS_STATIC_LO = 8;
    // per-line request codes
    localparam logic [1:0] REQ_LOW  = 2'h0;
    localparam logic [1:0] REQ_HIGH = 2'h1;
    localparam logic [1:0] REQ_KEEP = 2'h2;
    localparam logic [7:0] STATIC_RESET = 8'h00;
endpackage : trig_out_pkg
`default_nettype wire

// ===== rtl/debug_trigger_output_pins.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_output_pins #(
    parameter int SRC_W = trig_out_pkg::SRC_WIDTH,
    parameter int SEL_W = trig_out_pkg::SEL_WIDTH
) (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       upper_cable_lines_as_outputs,
    input  wire logic                       breakHit,
    input  wire logic                       breakClear,
    input  wire logic                       tracePointHit,
    input  wire logic                       traceExtract,
    input  wire logic [SRC_W-1:0]           eventSrc,
    input  wire logic [5*SEL_W-1:0]         eventSel,
    input  wire logic [15:0]                staticReq,
    input  wire logic                       applyStatic,
    output logic      [15:0]                trigLines,
    output logic      [15:0]                trigLinesOe,
    output logic      [7:0]                 staticLevel
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (SRC_W > (1 << SEL_W) || SRC_W < 1) begin : g_bad
        $error("eventSrc width does not fit the selector");
    end

    // ----------------------------------------
    // static lines
    // ----------------------------------------
    logic [7:0] static_q;
    logic [7:0] static_d;
    always_comb begin
        static_d = static_q;
        for (int i = 0; i < trig_out_pkg::STATIC_COUNT; i++) begin
            case (staticReq[2*i +: 2])
                trig_out_pkg::REQ_LOW:  static_d[i] = 1'b0;
                trig_out_pkg::REQ_HIGH: static_d[i] = 1'b1;
                default:                static_d[i] = static_q[i];
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            static_q <= trig_out_pkg::STATIC_RESET;
        end else if (applyStatic) begin
            static_q <= static_d;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            staticLevel <= trig_out_pkg::STATIC_RESET;
        end else begin
            staticLevel <= trigLines[15:8];
        end
    end

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    logic       breakLatch_q;
    logic [7:0] detect;
    always_ff @(posedge mclk) begin
        if (rst) begin
            breakLatch_q <= 1'b0;
        end else if (breakHit) begin
            breakLatch_q <= 1'b1;
        end else if (breakClear) begin
            breakLatch_q <= 1'b0;
        end
    end
    always_comb begin
        detect = 8'h00;
        detect[trig_out_pkg::POS_BREAK]   = breakLatch_q | breakHit;
        detect[trig_out_pkg::POS_TRACEPT] = tracePointHit;
        detect[trig_out_pkg::POS_EXTRACT] = traceExtract;
        for (int e = 0; e < trig_out_pkg::EVENT_COUNT; e++) begin
            detect[e] = eventSrc[eventSel[e*SEL_W +: SEL_W]];
        end
    end

    // ----------------------------------------
    // delay pipeline
    // ----------------------------------------
    // the pin flop is the last of the eight stages
    logic [7:0] pipe_q [trig_out_pkg::PIPE_DEPTH-1];
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int s = 0; s < trig_out_pkg::PIPE_DEPTH - 1; s++) begin
                pipe_q[s] <= 8'h00;
            end
        end else begin
            pipe_q[0] <= detect;
            for (int s = 1; s < trig_out_pkg::PIPE_DEPTH - 1; s++) begin
                pipe_q[s] <= pipe_q[s-1];
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            trigLines   <= 16'h0000;
            trigLinesOe <= 16'h0000;
        end else if (upper_cable_lines_as_outputs) begin
            trigLines   <= {static_q, pipe_q[trig_out_pkg::PIPE_DEPTH-2]};
            trigLinesOe <= 16'hffff;
        end else begin
            trigLines   <= 16'h0000;
            trigLinesOe <= 16'h0000;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_tp;
        tracePointHit && upper_cable_lines_as_outputs;
    endsequence
    sequence s_ex;
        traceExtract && upper_cable_lines_as_outputs;
    endsequence
    sequence s_brk_hit;
        breakHit && upper_cable_lines_as_outputs;
    endsequence
    sequence s_brk_held;
        breakLatch_q && !breakClear;
    endsequence
    sequence s_dir_held8;
        upper_cable_lines_as_outputs [*8];
    endsequence
    AST_TRACE_DELAY: assert property (@(posedge mclk) disable iff (rst)
        s_tp ##1 s_dir_held8 |-> trigLines[trig_out_pkg::POS_TRACEPT])
        else $error("trace point line not high eight cycles after hit");
    AST_EXTRACT_SET: assert property (@(posedge mclk) disable iff (rst)
        s_ex ##1 s_dir_held8 |-> trigLines[trig_out_pkg::POS_EXTRACT])
        else $error("extract line not high eight cycles after extract");
    AST_TRACE_LOW: assert property (@(posedge mclk) disable iff (rst)
        trigLines[trig_out_pkg::POS_TRACEPT] |-> $past(tracePointHit, 8))
        else $error("trace point line high without hit");
    AST_EXTRACT: assert property (@(posedge mclk) disable iff (rst)
        trigLines[trig_out_pkg::POS_EXTRACT] |-> $past(traceExtract, 8))
        else $error("extract line high without extract");
    AST_BREAK_SET: assert property (@(posedge mclk) disable iff (rst)
        s_brk_hit ##1 upper_cable_lines_as_outputs [*7] |=> trigLines[trig_out_pkg::POS_BREAK])
        else $error("breakpoint line not raised");
    AST_BREAK_HOLD: assert property (@(posedge mclk) disable iff (rst)
        s_brk_held ##1 s_dir_held8 |=> trigLines[trig_out_pkg::POS_BREAK])
        else $error("breakpoint line dropped");
    AST_APPLY: assert property (@(posedge mclk) disable iff (rst)
        !applyStatic |=> $stable(static_q))
        else $error("static lines changed without apply");
    AST_STATIC_OUT: assert property (@(posedge mclk) disable iff (rst)
        upper_cable_lines_as_outputs |=> trigLines[15:8] == $past(static_q))
        else $error("static lines not driven");
    AST_DIR: assert property (@(posedge mclk) disable iff (rst)
        !upper_cable_lines_as_outputs |=> trigLinesOe == 16'h0000)
        else $error("lines driven while all inputs");
    AST_READBACK: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> staticLevel == $past(trigLines[15:8]))
        else $error("readback mismatch");
    AST_DIR_ON: assert property (@(posedge mclk) disable iff (rst)
        upper_cable_lines_as_outputs |=> trigLinesOe == 16'hffff)
        else $error("lines not driven while upper lines are outputs");
    AST_RESET_LOW: assert property (@(posedge mclk)
        rst |=> trigLines == 16'h0000 && trigLinesOe == 16'h0000 && staticLevel == 8'h00
            && static_q == 8'h00 && !breakLatch_q)
        else $error("outputs not cleared by reset");

    // ----------------------------------------
    // per-line checks
    // ----------------------------------------
    for (genvar e = 0; e < trig_out_pkg::EVENT_COUNT; e++) begin : g_evt_chk
        AST_EVENT_SET: assert property (@(posedge mclk) disable iff (rst)
            eventSrc[eventSel[e*SEL_W +: SEL_W]] && upper_cable_lines_as_outputs
            ##1 upper_cable_lines_as_outputs [*7] |=> trigLines[trig_out_pkg::POS_EVENT_LO + e])
            else $error("event line not raised");
        AST_EVENT_LOW: assert property (@(posedge mclk) disable iff (rst)
            trigLines[trig_out_pkg::POS_EVENT_LO + e]
            |-> $past(eventSrc[eventSel[e*SEL_W +: SEL_W]], 8))
            else $error("event line high without event");
    end
    for (genvar i = 0; i < trig_out_pkg::STATIC_COUNT; i++) begin : g_static_chk
        AST_STATIC_SET: assert property (@(posedge mclk) disable iff (rst)
            applyStatic && staticReq[2*i +: 2] == trig_out_pkg::REQ_HIGH |=> static_q[i])
            else $error("static line not set high");
        AST_STATIC_CLR: assert property (@(posedge mclk) disable iff (rst)
            applyStatic && staticReq[2*i +: 2] == trig_out_pkg::REQ_LOW |=> !static_q[i])
            else $error("static line not set low");
        AST_STATIC_KEEP: assert property (@(posedge mclk) disable iff (rst)
            applyStatic && staticReq[2*i +: 2] != trig_out_pkg::REQ_LOW
            && staticReq[2*i +: 2] != trig_out_pkg::REQ_HIGH |=> $stable(static_q[i]))
            else $error("kept static line changed");
    end
endmodule : debug_trigger_output_pins
`default_nettype wire

// ===== testbench/trig_cable_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side equipment seen through the cable
// ----------------------------------------
module trig_cable_model (
    input  wire logic        mclk,
    input  wire logic [15:0] trigLines,
    input  wire logic [15:0] trigLinesOe,
    output logic      [15:0] cableLevel
);
    logic [15:0] floatPat = 16'h0000;
    // undriven lines toggle so a stale level is never read as valid
    always_ff @(posedge mclk) begin
        floatPat <= ~floatPat;
    end
    assign cableLevel = (trigLines & trigLinesOe) | (floatPat & ~trigLinesOe);
endmodule : trig_cable_model
`default_nettype wire

// ===== testbench/debug_trigger_output_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_output_pins_tb;
    // ----------------------------------------
    // stimulus, table and checks
    // ----------------------------------------
    typedef struct packed {logic tp; logic ex; logic [15:0] src; logic [19:0] sel; logic [6:0] exp;} row_s;
    logic        mclk = 1'b0, rst = 1'b1, upOut = 1'b1, bHit = 1'b0, bClr = 1'b0;
    logic        tp = 1'b0, ex = 1'b0, app = 1'b0;
    logic [15:0] src = 16'h0000, req = 16'h0000, trigLines, trigLinesOe, cableLevel;
    logic [19:0] sel = 20'h00000;
    logic [7:0]  staticLevel;
    int          err_count = 0, compares = 0, cycles = 0;
    row_s        rows [5] = '{'{1'b1, 1'b0, 16'h0000, 20'h00000, 7'h40},
                              '{1'b0, 1'b1, 16'h0000, 20'h00000, 7'h20},
                              '{1'b0, 1'b0, 16'h0004, 20'h21232, 7'h15},
                              '{1'b1, 1'b1, 16'h8000, 20'hfffff, 7'h7f},
                              '{1'b0, 1'b0, 16'h8000, 20'h00000, 7'h00}};
    debug_trigger_output_pins i_dut (.mclk(mclk), .rst(rst), .upper_cable_lines_as_outputs(upOut),
        .breakHit(bHit), .breakClear(bClr), .tracePointHit(tp), .traceExtract(ex), .eventSrc(src),
        .eventSel(sel), .staticReq(req), .applyStatic(app), .trigLines(trigLines),
        .trigLinesOe(trigLinesOe), .staticLevel(staticLevel));
    trig_cable_model i_cable (.mclk(mclk), .trigLines(trigLines), .trigLinesOe(trigLinesOe),
        .cableLevel(cableLevel));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic nclk(input int n);
        repeat (n) @(negedge mclk);
    endtask : nclk
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apply(input logic [15:0] r, input logic [7:0] e);
        req = r;
        app = 1'b1;
        nclk(1);
        app = 1'b0;
        nclk(2);
        chk({8'h00, trigLines[15:8]}, {8'h00, e});
        chk({8'h00, cableLevel[15:8]}, {8'h00, e});
        nclk(1);
        chk({8'h00, staticLevel}, {8'h00, e});
    endtask : apply
    task automatic close_out();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        nclk(16);
        rst = 1'b0;
        nclk(1);
        chk(trigLines, 16'h0000);
        chk(trigLinesOe, 16'hffff);
        foreach (rows[i]) begin
            {tp, ex, src, sel} = rows[i][44:7];
            nclk(1);
            {tp, ex, src} = 18'h00000;
            nclk(6);
            chk(trigLines, 16'h0000);
            nclk(1);
            chk({9'h000, trigLines[6:0]}, {9'h000, rows[i].exp});
            nclk(1);
            chk(trigLines, 16'h0000);
        end
        $display("event table done");
        req = 16'h5555;
        nclk(4);
        chk(trigLines, 16'h0000);
        apply(16'h5555, 8'hff);
        apply(16'hfaa0, 8'hfc);
        apply(16'h4411, 8'ha5);
        upOut = 1'b0;
        nclk(2);
        chk(trigLines, 16'h0000);
        chk(trigLinesOe, 16'h0000);
        upOut = 1'b1;
        nclk(2);
        $display("static and direction done");
        bHit = 1'b1;
        nclk(1);
        bHit = 1'b0;
        nclk(12);
        chk({15'h0000, trigLines[7]}, 16'h0001);
        nclk(20);
        chk({15'h0000, trigLines[7]}, 16'h0001);
        bClr = 1'b1;
        nclk(1);
        bClr = 1'b0;
        nclk(12);
        chk({15'h0000, trigLines[7]}, 16'h0000);
        bHit = 1'b1;
        nclk(1);
        bHit = 1'b0;
        nclk(12);
        rst = 1'b1;
        nclk(2);
        rst = 1'b0;
        nclk(1);
        chk(trigLines, 16'h0000);
        chk({8'h00, staticLevel}, 16'h0000);
        nclk(9);
        chk(trigLines, 16'h0000);
        $display("breakpoint and reset done");
        close_out();
    end
endmodule : debug_trigger_output_pins_tb
`default_nettype wire
